// file: hw/eth_port_frame_statistics.sv
/*
 * Per-port frame statistics: classifies receive and transmit completion
 * status from the port MAC, feeds the counter bank, issues jam and pause
 * send requests, and serves counters and configuration over Wishbone.
 * Assumes all status inputs are single-cycle pulses or levels from logic
 * on CLK_IN, valid in the cycle of their done strobe.
 */
`timescale 1ns/1ps
module eth_port_frame_statistics
	import stat_pkg::*;
#(
	parameter logic [LEN_W-1:0] RX_MAX_LEN_DEFAULT = MAX_LEN_RST
)
(
	input  wire logic                CLK_IN,              // MAC clock, 125 MHz
	input  wire logic                SYS_RST_IN,          // synchronous reset, high
	// wishbone slave
	input  wire logic                WB_CYC_IN,           // bus cycle
	input  wire logic                WB_STB_IN,           // strobe
	input  wire logic                WB_WE_IN,            // write enable
	input  wire logic [ADR_W-1:0]    WB_ADR_IN,           // byte address
	input  wire logic [3:0]          WB_SEL_IN,           // byte lanes
	input  wire logic [CNT_W-1:0]    WB_DAT_IN,           // write data
	output logic [CNT_W-1:0]         WB_DAT_OUT,          // read data
	output logic                     WB_ACK_OUT,          // acknowledge
	// receive completion status
	input  wire logic                RX_DONE_IN,          // frame received, pulse
	input  wire logic [LEN_W-1:0]    RX_LEN_IN,           // frame length in bytes
	input  wire logic                RX_IS_DATA_IN,       // data frame
	input  wire logic                RX_IS_CTRL_IN,       // MAC control frame
	input  wire logic                RX_ADDR_MATCH_IN,    // address filter hit
	input  wire logic                RX_PROMISC_IN,       // accepted promiscuously
	input  wire logic                RX_CRC_ERR_IN,       // bad CRC
	input  wire logic                RX_ALIGN_ERR_IN,     // alignment error
	input  wire logic                RX_CODE_ERR_IN,      // code error
	input  wire logic                RX_FC_COLL_IN,       // made by collision flow control
	input  wire logic                RX_START_IN,         // reception begins, pulse
	// transmit status
	input  wire logic                TX_COLL_IN,          // collision seen, pulse
	input  wire logic                TX_COLL_LATE_IN,     // that collision is late
	input  wire logic                TX_DONE_IN,          // frame finished, pulse
	input  wire logic [LEN_W-1:0]    TX_LEN_IN,           // frame length in bytes
	input  wire logic                TX_BCAST_IN,         // all-ones destination
	input  wire logic                TX_MCAST_IN,         // multicast destination
	input  wire logic                TX_PAUSE_GEN_IN,     // MAC-built pause frame
	input  wire logic                TX_DEFERRED_IN,      // medium busy at first try
	input  wire logic [COLL_W-1:0]   TX_COLL_CNT_IN,      // collisions, late included
	input  wire logic                TX_LATE_COLL_IN,     // ended by late collision
	input  wire logic                TX_EXCESS_COLL_IN,   // abandoned, too many tries
	input  wire logic                TX_CARRIER_LOSS_IN,  // carrier lost
	input  wire logic                TX_UNDERRUN_IN,      // underrun
	input  wire logic                PAUSE_REQ_IN,        // flow control wants pause
	output logic                     JAM_SEND_OUT,        // send jam, pulse
	output logic                     PAUSE_SEND_OUT       // build pause frame, pulse
);
	typedef struct packed
	{
		bus_state_t          bus;
		logic                ack;
		logic [CNT_W-1:0]    dat;
		logic                full_duplex;
		logic                flow_en;
		logic [LEN_W-1:0]    max_len;
		logic                jam;
		logic                pause;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;

	stat_bank_if #(.N(NUM_CNT), .W(CNT_W)) bank_bus ();

	stat_counter_bank #(.N(NUM_CNT), .W(CNT_W)) u_bank
	(
		.clk_in (CLK_IN),
		.rst_in (SYS_RST_IN),
		.bus    (bank_bus.bank)
	);

	logic                rx_err;
	logic                rx_kind;
	logic                rx_accept;
	logic                rx_short;
	logic                rx_good_len;
	logic                tx_clean;
	logic                tx_good;
	logic                tx_ok;
	logic                half_dup_fc;
	logic [1:0]          size64_hits;
	logic [COLL_W:0]     coll_amt;
	logic                req;
	logic                in_map;
	logic [CNT_W-1:0]    wr_mask;
	logic [CNT_W-1:0]    cfg_word;
	logic [CNT_W-1:0]    len_word;

	// receive classification
	assign rx_err      = RX_CRC_ERR_IN | RX_ALIGN_ERR_IN | RX_CODE_ERR_IN;
	assign rx_kind     = RX_IS_DATA_IN | RX_IS_CTRL_IN;
	assign rx_accept   = RX_ADDR_MATCH_IN | RX_PROMISC_IN;
	assign rx_short    = RX_LEN_IN < MIN_FRAME_LEN;
	assign rx_good_len = !rx_short && (RX_LEN_IN <= s_q.max_len);

	// transmit classification; carrier loss and underrun cannot touch
	// generated pause frames, so they are taken as sent
	assign tx_clean = !TX_CARRIER_LOSS_IN && !TX_UNDERRUN_IN;
	assign tx_good  = tx_clean && !TX_LATE_COLL_IN && !TX_EXCESS_COLL_IN;
	assign tx_ok    = TX_DONE_IN && (tx_good || TX_PAUSE_GEN_IN); // RL10

	assign half_dup_fc = !s_q.full_duplex && s_q.flow_en && RX_START_IN;

	assign coll_amt = ((TX_DONE_IN && tx_clean) ? {1'b0, TX_COLL_CNT_IN} : '0)
		+ (COLL_W+1)'(half_dup_fc);

	// rx and tx can both finish a 64-byte frame in one cycle
	assign size64_hits = 2'(RX_DONE_IN && rx_kind && (RX_LEN_IN == MIN_FRAME_LEN))
		+ 2'(tx_ok && (TX_PAUSE_GEN_IN || (TX_LEN_IN == MIN_FRAME_LEN))); // RL8

	always_comb
	begin
		bank_bus.inc = '0;
		bank_bus.inc[SLOT_RX_SHORT] = CNT_W'(RX_DONE_IN && rx_kind && rx_accept && rx_short && !rx_err); // RL1
		bank_bus.inc[SLOT_RX_FRAG] = CNT_W'(RX_DONE_IN && RX_IS_DATA_IN && rx_short && rx_err
			&& !RX_FC_COLL_IN); // RL2
		if (RX_DONE_IN && rx_kind && rx_accept && rx_good_len && !rx_err)
			bank_bus.inc[SLOT_RX_BYTES] = CNT_W'(RX_LEN_IN); // RL3
		bank_bus.inc[SLOT_TX_GOOD] = CNT_W'(tx_ok); // RL4
		bank_bus.inc[SLOT_TX_BCAST] = CNT_W'(tx_ok && TX_BCAST_IN); // RL5
		bank_bus.inc[SLOT_TX_MCAST] = CNT_W'(tx_ok && !TX_BCAST_IN
			&& (TX_MCAST_IN || TX_PAUSE_GEN_IN)); // RL6 RL8
		bank_bus.inc[SLOT_TX_PAUSE] = CNT_W'(TX_DONE_IN && TX_PAUSE_GEN_IN); // RL7 RL9
		bank_bus.inc[SLOT_TX_WAIT] = CNT_W'(TX_DONE_IN && TX_DEFERRED_IN && tx_good
			&& (TX_COLL_CNT_IN == '0)); // RL11
		bank_bus.inc[SLOT_TX_COLL] = CNT_W'(coll_amt); // RL12 RL14
		bank_bus.inc[SLOT_TX_ONE] = CNT_W'(TX_DONE_IN && tx_good
			&& (TX_COLL_CNT_IN == ONE_COLLISION)); // RL15
		bank_bus.inc[SLOT_SIZE64] = CNT_W'(size64_hits);
	end

	// register slave
	assign req     = WB_CYC_IN && WB_STB_IN;
	assign in_map  = (WB_ADR_IN <= OFS_CNT_LAST) && (WB_ADR_IN[1:0] == 2'b00);
	assign bank_bus.rd_idx = WB_ADR_IN[IDX_W+1:2];

	genvar b;
	generate
		for (b = 0; b < 4; b++)
		begin : g_lane
			assign wr_mask[8*b +: 8] = {8{WB_SEL_IN[b]}};
		end
	endgenerate

	always_comb
	begin
		cfg_word = '0;
		cfg_word[CFG_FULL_DUPLEX_BIT] = s_q.full_duplex;
		cfg_word[CFG_FLOW_EN_BIT] = s_q.flow_en;
		len_word = CNT_W'(s_q.max_len);
	end

	always_comb
	begin
		s_d = s_q;
		// jam only for collisions inside the slot time
		s_d.jam = TX_COLL_IN && !TX_COLL_LATE_IN; // RL13
		// half duplex never sees a generated pause frame
		s_d.pause = PAUSE_REQ_IN && s_q.full_duplex; // RL9
		case (s_q.bus)
			BUS_IDLE:
			begin
				s_d.ack = 1'b0;
				if (req)
					s_d.bus = BUS_FETCH;
			end
			BUS_FETCH:
			begin
				// counter word was latched by the bank at the previous edge
				s_d.bus = BUS_ACK;
				s_d.ack = 1'b1;
				if (WB_WE_IN)
					s_d.dat = '0;
				else if (in_map)
					s_d.dat = bank_bus.rd_data; // RL16
				else if (WB_ADR_IN == OFS_CFG)
					s_d.dat = cfg_word;
				else if (WB_ADR_IN == OFS_MAXLEN)
					s_d.dat = len_word;
				else
					s_d.dat = '0;
			end
			BUS_ACK:
			begin
				// writes land at the edge where the master takes ack;
				// counter writes are dropped, they are read only
				s_d.bus = BUS_IDLE;
				s_d.ack = 1'b0;
				if (WB_WE_IN && WB_ADR_IN == OFS_CFG)
				begin
					if (WB_SEL_IN[0])
					begin
						s_d.full_duplex = WB_DAT_IN[CFG_FULL_DUPLEX_BIT];
						s_d.flow_en = WB_DAT_IN[CFG_FLOW_EN_BIT];
					end
				end
				else if (WB_WE_IN && WB_ADR_IN == OFS_MAXLEN)
					s_d.max_len = LEN_W'((len_word & ~wr_mask) | (WB_DAT_IN & wr_mask));
			end
			default:
			begin
				s_d.bus = BUS_IDLE;
				s_d.ack = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			s_q.bus <= BUS_IDLE;
			s_q.ack <= 1'b0;
			s_q.dat <= '0;
			s_q.full_duplex <= CFG_FULL_DUPLEX_RST;
			s_q.flow_en <= CFG_FLOW_EN_RST;
			s_q.max_len <= RX_MAX_LEN_DEFAULT;
			s_q.jam <= 1'b0;
			s_q.pause <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign WB_DAT_OUT     = s_q.dat;
	assign WB_ACK_OUT     = s_q.ack;
	assign JAM_SEND_OUT   = s_q.jam;
	assign PAUSE_SEND_OUT = s_q.pause;

endmodule : eth_port_frame_statistics

// file: hw/stat_bank_if.sv
/*
 * Carrier between the statistics front end and its counter bank:
 * per-slot increment amounts, a read slot and the registered read word.
 * Assumes both ends share the MAC clock.
 */
`timescale 1ns/1ps
interface stat_bank_if
	import stat_pkg::*;
#(
	parameter int N = NUM_CNT,
	parameter int W = CNT_W
);
	logic [N-1:0][W-1:0] inc;
	logic [IDX_W-1:0]    rd_idx;
	logic [W-1:0]        rd_data;

	modport bank (input inc, input rd_idx, output rd_data);
	modport user (output inc, output rd_idx, input rd_data);
endinterface : stat_bank_if

// file: hw/stat_counter_bank.sv
/*
 * Bank of wrapping statistic counters, each advanced by its own amount in
 * one cycle, with a registered read port selected by slot.
 * Assumes amounts are presented for exactly one cycle per event.
 */
`timescale 1ns/1ps
module stat_counter_bank
	import stat_pkg::*;
#(
	parameter int N = NUM_CNT,
	parameter int W = CNT_W
)
(
	input  wire logic  clk_in,   // MAC clock
	input  wire logic  rst_in,   // synchronous reset
	stat_bank_if.bank  bus       // increments and read port
);
	typedef struct packed
	{
		logic [N-1:0][W-1:0] cnt;
		logic [W-1:0]        rd;
	} bank_state_t;

	bank_state_t         s_q;
	bank_state_t         s_d;
	logic [N-1:0][W-1:0] sum;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_cnt
			// plain modulo add: wraps to zero past all ones
			assign sum[g] = s_q.cnt[g] + bus.inc[g]; // RL17
		end
	endgenerate

	always_comb
	begin
		s_d = s_q;
		s_d.cnt = sum; // RL18
		s_d.rd = (32'(bus.rd_idx) < N) ? s_q.cnt[bus.rd_idx] : '0;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			s_q <= '0; // RL16
		else
			s_q <= s_d;
	end

	assign bus.rd_data = s_q.rd;

endmodule : stat_counter_bank

// file: hw/stat_pkg.sv
/*
 * Constants shared by the per-port frame statistics block: counter slots,
 * register offsets, field positions, reset values and frame-size limits.
 * Assumes a single MAC clock domain and 32-bit classic Wishbone access.
 */
// Operation
// RL1 - count short, address-matched, error-free received data or control frames
// RL2 - count short received data frames with errors, except flow-control collisions
// RL3 - add byte length of good received frames, 64 up to maximum, to total
// RL4 - count transmitted frames ending without late, excessive collision, carrier loss, underrun
// RL5 - count good transmitted frames sent to the all-ones broadcast address
// RL6 - count good transmitted frames sent to non-broadcast multicast addresses
// RL7 - count only pause frames the MAC generates, not software-supplied ones
// RL8 - generated pause frames are 64-byte multicast, counted in those counters too
// RL9 - generate pause frames only in full duplex
// RL10 - pause count ignores underrun and CRC conditions
// RL11 - count frames deferred at first attempt, then sent cleanly without collisions
// RL12 - collision counter adds every collision, late ones included, on clean frames
// RL13 - send a jam sequence on every collision that is not late
// RL14 - collision counter also bumps on receive start in half duplex with flow control
// RL15 - count frames sent after exactly one non-late collision, no carrier loss or underrun
// RL16 - each statistic is a 32-bit read-only field cleared at reset
// RL17 - counters wrap to zero, byte total accumulates modulo two to the 32nd
// RL18 - all counters qualifying on one event update in the same cycle
package stat_pkg;

	localparam int CNT_W   = 32;
	localparam int NUM_CNT = 11;
	localparam int LEN_W   = 16;
	localparam int IDX_W   = 4;
	localparam int ADR_W   = 8;
	localparam int COLL_W  = 5;

	// counter slots, register byte offset is slot times four
	localparam logic [IDX_W-1:0] SLOT_RX_SHORT = 4'h0;
	localparam logic [IDX_W-1:0] SLOT_RX_FRAG  = 4'h1;
	localparam logic [IDX_W-1:0] SLOT_RX_BYTES = 4'h2;
	localparam logic [IDX_W-1:0] SLOT_TX_GOOD  = 4'h3;
	localparam logic [IDX_W-1:0] SLOT_TX_BCAST = 4'h4;
	localparam logic [IDX_W-1:0] SLOT_TX_MCAST = 4'h5;
	localparam logic [IDX_W-1:0] SLOT_TX_PAUSE = 4'h6;
	localparam logic [IDX_W-1:0] SLOT_TX_WAIT  = 4'h7;
	localparam logic [IDX_W-1:0] SLOT_TX_COLL  = 4'h8;
	localparam logic [IDX_W-1:0] SLOT_TX_ONE   = 4'h9;
	localparam logic [IDX_W-1:0] SLOT_SIZE64   = 4'ha;

	localparam logic [ADR_W-1:0] OFS_CNT_LAST = 8'h28;
	localparam logic [ADR_W-1:0] OFS_CFG      = 8'h40;
	localparam logic [ADR_W-1:0] OFS_MAXLEN   = 8'h44;

	localparam int CFG_FULL_DUPLEX_BIT = 0;
	localparam int CFG_FLOW_EN_BIT     = 1;
	localparam logic CFG_FULL_DUPLEX_RST = 1'b1;
	localparam logic CFG_FLOW_EN_RST     = 1'b0;

	localparam logic [LEN_W-1:0] MIN_FRAME_LEN  = 16'h0040;
	localparam logic [LEN_W-1:0] MAX_LEN_RST    = 16'h05ee;
	localparam logic [COLL_W-1:0] ONE_COLLISION = 5'h01;

	typedef enum logic [2:0]
	{
		BUS_IDLE  = 3'b001,
		BUS_FETCH = 3'b010,
		BUS_ACK   = 3'b100
	} bus_state_t;

endpackage : stat_pkg

// file: tb/eth_port_frame_statistics_tb_top.sv
/*
 * Self-checking bench for the frame statistics block: drives status via
 * the MAC model, reads counters over Wishbone against its own totals.
 */
`timescale 1ns/1ps
module eth_port_frame_statistics_tb_top;
	import stat_pkg::*;
	logic        clk, rst, cyc, stb, we, preq;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rd;
	logic [31:0] exp_cnt [NUM_CNT];
	wire [31:0]  dout;
	wire         ack, jam, psend, rxd, rxs, txd, col, coll;
	wire [15:0]  rxl, txl;
	wire [7:0]   rxf, txf;
	wire [4:0]   txc;
	int          num_errors, checked;

	eth_port_frame_statistics i_eth_port_frame_statistics (.CLK_IN(clk), .SYS_RST_IN(rst),
		.WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
		.WB_DAT_IN(wdat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack), .RX_DONE_IN(rxd), .RX_LEN_IN(rxl),
		.RX_IS_DATA_IN(rxf[7]), .RX_IS_CTRL_IN(rxf[6]), .RX_ADDR_MATCH_IN(rxf[5]), .RX_PROMISC_IN(rxf[4]),
		.RX_CRC_ERR_IN(rxf[3]), .RX_ALIGN_ERR_IN(rxf[2]), .RX_CODE_ERR_IN(rxf[1]), .RX_FC_COLL_IN(rxf[0]),
		.RX_START_IN(rxs), .TX_COLL_IN(col), .TX_COLL_LATE_IN(coll), .TX_DONE_IN(txd), .TX_LEN_IN(txl),
		.TX_BCAST_IN(txf[7]), .TX_MCAST_IN(txf[6]), .TX_PAUSE_GEN_IN(txf[5]), .TX_DEFERRED_IN(txf[4]),
		.TX_COLL_CNT_IN(txc), .TX_LATE_COLL_IN(txf[3]), .TX_EXCESS_COLL_IN(txf[2]),
		.TX_CARRIER_LOSS_IN(txf[1]), .TX_UNDERRUN_IN(txf[0]), .PAUSE_REQ_IN(preq),
		.JAM_SEND_OUT(jam), .PAUSE_SEND_OUT(psend));
	mac_status_model i_mac_status_model (.clk_in(clk), .rx_done_out(rxd), .rx_len_out(rxl),
		.rx_flag_out(rxf), .rx_start_out(rxs), .tx_done_out(txd), .tx_len_out(txl), .tx_flag_out(txf),
		.tx_coll_cnt_out(txc), .coll_out(col), .coll_late_out(coll));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : cmp
	task cmpb(input logic g, input logic e, input string m);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %0t %s got %b exp %b", $time, m, g, e);
		end
	endtask : cmpb
	// no fixed latency assumed: wait for ack under a bound
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		cmpb(ack, 1'b1, "bus ack");
		rd = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, '0);
		cmp(rd, e, $sformatf("reg %h", a));
	endtask : rdchk
	task check_all();
		for (int i = 0; i < NUM_CNT; i++)
			rdchk(8'(i * 4), exp_cnt[i]);
	endtask : check_all
	task t_reset();
		check_all();
		rdchk(OFS_CFG, 32'h00000001);
		rdchk(OFS_MAXLEN, 32'h000005ee);
		rdchk(8'h80, 32'h00000000);
	endtask : t_reset
	task t_readonly();
		wb(1'b1, 8'h00, 32'hffffffff);
		wb(1'b1, 8'h08, 32'hffffffff);
		wb(1'b1, 8'h90, 32'hffffffff);
		check_all();
	endtask : t_readonly
	task t_rx();
		i_mac_status_model.rx(16'd63, 8'ha0);
		i_mac_status_model.rx(16'd63, 8'h50);
		i_mac_status_model.rx(16'd63, 8'h80);
		i_mac_status_model.rx(16'd63, 8'h88);
		i_mac_status_model.rx(16'd63, 8'ha4);
		i_mac_status_model.rx(16'd63, 8'h82);
		i_mac_status_model.rx(16'd63, 8'h89);
		i_mac_status_model.rx(16'd63, 8'h48);
		i_mac_status_model.rx(16'd64, 8'ha0);
		i_mac_status_model.rx(16'd1518, 8'ha0);
		i_mac_status_model.rx(16'd1519, 8'ha0);
		i_mac_status_model.rx(16'd100, 8'ha8);
		i_mac_status_model.rx(16'd100, 8'h80);
		wb(1'b1, OFS_MAXLEN, 32'h00000100);
		i_mac_status_model.rx(16'd256, 8'h90);
		i_mac_status_model.rx(16'd257, 8'ha0);
		wb(1'b1, OFS_MAXLEN, 32'h000005ee);
		exp_cnt[SLOT_RX_SHORT] += 2;
		exp_cnt[SLOT_RX_FRAG] += 3;
		exp_cnt[SLOT_RX_BYTES] += 1838;
		exp_cnt[SLOT_SIZE64] += 1;
		check_all();
	endtask : t_rx
	task t_tx();
		i_mac_status_model.tx(16'd100, 8'hc0, 5'd0);
		i_mac_status_model.tx(16'd64, 8'h40, 5'd0);
		i_mac_status_model.tx(16'd100, 8'h00, 5'd0);
		i_mac_status_model.tx(16'd100, 8'h48, 5'd2);
		i_mac_status_model.tx(16'd100, 8'h04, 5'd15);
		i_mac_status_model.tx(16'd100, 8'h02, 5'd3);
		i_mac_status_model.tx(16'd100, 8'h01, 5'd1);
		i_mac_status_model.tx(16'd100, 8'h10, 5'd0);
		i_mac_status_model.tx(16'd100, 8'h10, 5'd1);
		i_mac_status_model.tx(16'd100, 8'h00, 5'd1);
		i_mac_status_model.tx(16'd100, 8'h00, 5'd2);
		i_mac_status_model.tx(16'd100, 8'h08, 5'd1);
		exp_cnt[SLOT_TX_GOOD] += 7;
		exp_cnt[SLOT_TX_BCAST] += 1;
		exp_cnt[SLOT_TX_MCAST] += 1;
		exp_cnt[SLOT_SIZE64] += 1;
		exp_cnt[SLOT_TX_WAIT] += 1;
		exp_cnt[SLOT_TX_COLL] += 22;
		exp_cnt[SLOT_TX_ONE] += 2;
		check_all();
	endtask : t_tx
	task t_jam();
		i_mac_status_model.coll(1'b0);
		#1 cmpb(jam, 1'b1, "jam early");
		i_mac_status_model.coll(1'b1);
		#1 cmpb(jam, 1'b0, "jam late");
	endtask : t_jam
	task pause_pulse(input logic e);
		@(posedge clk);
		preq <= 1'b1;
		@(posedge clk);
		preq <= 1'b0;
		#1 cmpb(psend, e, "pause send");
	endtask : pause_pulse
	task t_pause();
		pause_pulse(1'b1);
		i_mac_status_model.pause_frame();
		i_mac_status_model.tx(16'd64, 8'h40, 5'd0);
		wb(1'b1, OFS_CFG, 32'h00000002);
		pause_pulse(1'b0);
		i_mac_status_model.start();
		wb(1'b1, OFS_CFG, 32'h00000003);
		i_mac_status_model.start();
		wb(1'b1, OFS_CFG, 32'h00000000);
		i_mac_status_model.start();
		wb(1'b1, OFS_CFG, 32'h00000001);
		exp_cnt[SLOT_TX_GOOD] += 2;
		exp_cnt[SLOT_TX_MCAST] += 2;
		exp_cnt[SLOT_TX_PAUSE] += 1;
		exp_cnt[SLOT_SIZE64] += 2;
		exp_cnt[SLOT_TX_COLL] += 1;
		check_all();
	endtask : t_pause
	// partial lanes: max length takes lane 0 only, config ignores a write without lane 0
	task t_lanes();
		sel <= 4'h1;
		wb(1'b1, OFS_MAXLEN, 32'h0000ffff);
		sel <= 4'he;
		wb(1'b1, OFS_CFG, 32'h00000000);
		sel <= 4'hf;
		rdchk(OFS_MAXLEN, 32'h000005ff);
		rdchk(OFS_CFG, 32'h00000001);
		wb(1'b1, OFS_MAXLEN, 32'h000005ee);
	endtask : t_lanes
	// rx and tx finish a 64-byte frame at the same edge
	task t_both();
		fork
			i_mac_status_model.rx(16'd64, 8'ha0);
			i_mac_status_model.tx(16'd64, 8'h40, 5'd0);
		join
		exp_cnt[SLOT_RX_BYTES] += 64;
		exp_cnt[SLOT_TX_GOOD] += 1;
		exp_cnt[SLOT_TX_MCAST] += 1;
		exp_cnt[SLOT_SIZE64] += 2;
		check_all();
	endtask : t_both
	task results();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	initial
	begin
		{rst, cyc, stb, we, preq, adr, wdat} = {1'b1, 44'h0};
		sel = 4'hf;
		num_errors = 0;
		checked = 0;
		foreach (exp_cnt[i])
			exp_cnt[i] = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_readonly();
		t_rx();
		t_tx();
		t_jam();
		t_pause();
		t_lanes();
		t_both();
		results();
	end
	// run needs about 410 cycles
	initial
	begin
		#100000;
		num_errors++;
		results();
	end
endmodule : eth_port_frame_statistics_tb_top

// file: tb/eth_stat_properties.sv
/*
 * Port checker for the frame statistics block: bus timing, jam and pause.
 * Bound to the block; one clock, synchronous reset.
 */
`timescale 1ns/1ps
module eth_stat_properties
	import stat_pkg::*;
(
	input wire logic             CLK_IN,         // clock
	input wire logic             SYS_RST_IN,     // reset
	input wire logic             WB_CYC_IN,      // cycle
	input wire logic             WB_STB_IN,      // strobe
	input wire logic             WB_WE_IN,       // write
	input wire logic [ADR_W-1:0] WB_ADR_IN,      // address
	input wire logic [CNT_W-1:0] WB_DAT_OUT,     // read data
	input wire logic             WB_ACK_OUT,     // ack
	input wire logic             TX_COLL_IN,     // collision
	input wire logic             TX_COLL_LATE_IN, // late
	input wire logic             PAUSE_REQ_IN,   // pause wanted
	input wire logic             JAM_SEND_OUT,   // jam
	input wire logic             PAUSE_SEND_OUT  // pause
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	// fetch state costs one edge, ack is registered at the next one
	ack_latency_a: assert property (WB_CYC_IN && WB_STB_IN && !$past(WB_CYC_IN) |->
		!WB_ACK_OUT [*2] ##1 WB_ACK_OUT) else $error("ack not two edges after request");
	ack_single_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack longer than one cycle");
	ack_held_a: assert property (WB_ACK_OUT |-> WB_CYC_IN && WB_STB_IN)
		else $error("ack without request");
	write_quiet_a: assert property (WB_ACK_OUT && WB_WE_IN |-> WB_DAT_OUT == '0)
		else $error("data on write ack");
	unmapped_zero_a: assert property (WB_ACK_OUT && WB_ADR_IN > OFS_MAXLEN |-> WB_DAT_OUT == '0)
		else $error("unmapped read not zero");
	jam_nonlate_a: assert property (TX_COLL_IN && !TX_COLL_LATE_IN |=> JAM_SEND_OUT)
		else $error("no jam after collision");
	jam_cause_a: assert property (JAM_SEND_OUT |-> $past(TX_COLL_IN && !TX_COLL_LATE_IN))
		else $error("jam without early collision");
	pause_cause_a: assert property (PAUSE_SEND_OUT |-> $past(PAUSE_REQ_IN))
		else $error("pause without request");
endmodule : eth_stat_properties

bind eth_port_frame_statistics eth_stat_properties i_eth_stat_properties (.*);

// file: tb/mac_status_model.sv
/*
 * Port MAC status source: frame completions, collisions, receive starts.
 * Qualifiers go to their inverse once a strobe is released.
 */
`timescale 1ns/1ps
module mac_status_model
(
	input  wire logic  clk_in,          // clock
	output logic       rx_done_out,     // rx status strobe
	output logic [15:0] rx_len_out,     // rx length
	output logic [7:0] rx_flag_out,     // data ctrl match promisc crc align code fc
	output logic       rx_start_out,    // rx begins
	output logic       tx_done_out,     // tx status strobe
	output logic [15:0] tx_len_out,     // tx length
	output logic [7:0] tx_flag_out,     // bc mc pause defer late excess carrier under
	output logic [4:0] tx_coll_cnt_out, // collisions
	output logic       coll_out,        // collision pulse
	output logic       coll_late_out    // collision late
);
	initial
	begin
		{rx_done_out, rx_len_out, rx_flag_out, rx_start_out, tx_done_out} = '0;
		{tx_len_out, tx_flag_out, tx_coll_cnt_out, coll_out, coll_late_out} = '0;
	end
	task rx(input logic [15:0] l, input logic [7:0] f);
		@(posedge clk_in);
		rx_done_out <= 1'b1;
		rx_len_out <= l;
		rx_flag_out <= f;
		@(posedge clk_in);
		rx_done_out <= 1'b0;
		rx_len_out <= ~l;
		rx_flag_out <= ~f;
	endtask : rx
	task tx(input logic [15:0] l, input logic [7:0] f, input logic [4:0] c);
		@(posedge clk_in);
		tx_done_out <= 1'b1;
		tx_len_out <= l;
		tx_flag_out <= f;
		tx_coll_cnt_out <= c;
		@(posedge clk_in);
		tx_done_out <= 1'b0;
		tx_len_out <= ~l;
		tx_flag_out <= ~f;
		tx_coll_cnt_out <= ~c;
	endtask : tx
	// mac-built pause: 64-byte multicast, underrun flag must not matter
	task pause_frame();
		tx(16'h0040, 8'h61, 5'h00);
	endtask : pause_frame
	task coll(input logic late);
		@(posedge clk_in);
		coll_out <= 1'b1;
		coll_late_out <= late;
		@(posedge clk_in);
		coll_out <= 1'b0;
		coll_late_out <= ~late;
	endtask : coll
	task start();
		@(posedge clk_in);
		rx_start_out <= 1'b1;
		@(posedge clk_in);
		rx_start_out <= 1'b0;
	endtask : start
endmodule : mac_status_model
